// *** hw/frcc_readback_mem.v ***
// crc readback storage, eight bytes, registered read port
// assumes one clock; locations past the stored bytes read as zero
`timescale 1ns/1ns
`default_nettype none
`include "frcc_defines.vh"
module frcc_readback_mem (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_clear,
  input wire i_load,
  input wire [63:0] i_load_data,
  input wire [6:0] i_rd_addr,
  output reg [7:0] o_rd_data
);
  reg [7:0] mem [0:7];
  integer i;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      o_rd_data <= 8'h00;
    end else begin
      if (i_clear) begin
        for (i = 0; i < 8; i = i + 1) begin
          mem[i] <= 8'h00;
        end
      end else if (i_load) begin
        for (i = 0; i < 8; i = i + 1) begin
          mem[i] <= i_load_data[i*8 +: 8];
        end
      end
      if (i_rd_addr < `FRCC_RB_BYTES) begin
        o_rd_data <= mem[i_rd_addr[2:0]];
      end else begin
        o_rd_data <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/frcc_top.v ***
// flash range crc check: spi command decode, crc engine, readback
// assumes spi pins asynchronous to i_clk, array port on i_clk
`timescale 1ns/1ns
`default_nettype none
`include "frcc_defines.vh"
module frcc_top (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_spi_sclk,
  input wire i_spi_cs_n,
  input wire i_spi_mosi,
  output reg o_spi_miso,
  output reg o_spi_miso_oe,
  input wire i_suspend_req,
  input wire i_soft_reset,
  input wire i_clear_flags,
  output reg o_mem_rd,
  output reg [31:0] o_mem_addr,
  input wire [7:0] i_mem_data,
  input wire i_mem_valid,
  output reg o_flag_ready,
  output reg o_flag_suspend,
  output reg o_flag_crc_fail,
  output reg o_flag_range_err
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_REQ = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  // one byte into the crc, lsb first, normal-form polynomial
  function [63:0] frcc_crc_byte;
    input [63:0] crc_in;
    input [7:0] data;
    reg [63:0] c;
    reg fb;
    integer k;
    begin
      c = crc_in;
      fb = 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        fb = c[63] ^ data[k];
        c = {c[62:0], 1'b0} ^ (fb ? `FRCC_POLY : 64'h0000000000000000);
      end
      frcc_crc_byte = c;
    end
  endfunction

  reg sclk_s1, sclk_s2, sclk_p;
  reg cs_s1, cs_s2, cs_p;
  reg mosi_s1, mosi_s2;
  reg [2:0] bit_cnt;
  reg [7:0] rx;
  reg [4:0] byte_cnt;
  reg seq_ok;
  reg rb_mode;
  reg [63:0] exp_crc;
  reg [31:0] start_addr;
  reg [31:0] end_addr;
  reg [2:0] tx_cnt;
  reg [7:0] tx;
  reg [6:0] rd_addr;
  reg [2:0] state;
  reg [31:0] cur_addr;
  reg [31:0] last_addr;
  reg [63:0] crc;
  reg [63:0] exp_hold;
  reg rb_clear;
  reg rb_load;
  wire [7:0] rd_data;
  wire [7:0] rx_next = {rx[6:0], mosi_s2};
  wire sclk_rise = sclk_s2 & ~sclk_p;
  wire sclk_fall = ~sclk_s2 & sclk_p;
  wire cs_rise = cs_s2 & ~cs_p;
  wire [63:0] crc_new = frcc_crc_byte(crc, i_mem_data);
  wire seq_done = seq_ok && (byte_cnt >= `FRCC_SEQ_LEN);
  wire fail_set = (state == ST_WAIT) && i_mem_valid && (cur_addr == last_addr) && (crc_new != exp_hold);
  wire range_set = cs_rise && seq_done && (state == ST_IDLE) && (end_addr < start_addr);

  // pin synchronisers
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_p <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_p <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= i_spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_p <= sclk_s2;
      cs_s1 <= i_spi_cs_n;
      cs_s2 <= cs_s1;
      cs_p <= cs_s2;
      mosi_s1 <= i_spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  // command byte receive
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt <= 3'h0;
      rx <= 8'h00;
      byte_cnt <= 5'h00;
      seq_ok <= 1'b0;
      rb_mode <= 1'b0;
      exp_crc <= 64'h0000000000000000;
      start_addr <= 32'h00000000;
      end_addr <= 32'h00000000;
    end else if (cs_s2) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      seq_ok <= 1'b0;
      rb_mode <= 1'b0;
    end else if (sclk_rise) begin
      rx <= rx_next;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != `FRCC_BYTE_CNT_MAX) begin
          byte_cnt <= byte_cnt + 5'h01;
        end
        if (byte_cnt == 5'h00) begin
          seq_ok <= (rx_next == `FRCC_CMD_IFACE);
          rb_mode <= (rx_next == `FRCC_CMD_READBACK);
        end else if (byte_cnt == 5'h01) begin
          seq_ok <= seq_ok & (rx_next == `FRCC_SUB_CRC);
        end else if (byte_cnt == 5'h02) begin
          seq_ok <= seq_ok & (rx_next == `FRCC_OPT_RANGE);
        end else if (byte_cnt <= 5'h0A) begin
          exp_crc <= {rx_next, exp_crc[63:8]};
        end else if (byte_cnt <= 5'h0E) begin
          start_addr <= {rx_next, start_addr[31:8]};
        end else if (byte_cnt <= 5'h12) begin
          end_addr <= {rx_next, end_addr[31:8]};
        end
      end
    end
  end

  // readback shift out on falling sclk, bytes in rising address order
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_cnt <= 3'h0;
      tx <= 8'h00;
      rd_addr <= 7'h00;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else if (cs_s2) begin
      tx_cnt <= 3'h0;
      rd_addr <= 7'h00;
      o_spi_miso_oe <= 1'b0;
    end else begin
      o_spi_miso_oe <= rb_mode;
      if (sclk_fall && rb_mode) begin
        tx_cnt <= tx_cnt + 3'h1;
        if (tx_cnt == 3'h0) begin
          o_spi_miso <= rd_data[7];
          tx <= {rd_data[6:0], 1'b0};
          if (rd_addr != `FRCC_RB_ADDR_MAX) begin
            rd_addr <= rd_addr + 7'h01;
          end
        end else begin
          o_spi_miso <= tx[7];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end

  // crc engine, started by chip select release
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      cur_addr <= 32'h00000000;
      last_addr <= 32'h00000000;
      crc <= `FRCC_CRC_INIT;
      exp_hold <= 64'h0000000000000000;
      o_mem_rd <= 1'b0;
      o_mem_addr <= 32'h00000000;
      o_flag_ready <= 1'b1;
      o_flag_suspend <= 1'b0;
      rb_clear <= 1'b0;
      rb_load <= 1'b0;
    end else if (i_soft_reset) begin
      state <= ST_IDLE;
      o_mem_rd <= 1'b0;
      o_flag_ready <= 1'b1;
      o_flag_suspend <= 1'b0;
      rb_clear <= 1'b1;
      rb_load <= 1'b0;
    end else begin
      rb_clear <= 1'b0;
      rb_load <= 1'b0;
      o_mem_rd <= 1'b0;
      case (state)
        ST_IDLE: begin
          // no write enable latch term here
          if (cs_rise && seq_done && !(end_addr < start_addr)) begin
            state <= ST_REQ;
            cur_addr <= start_addr;
            last_addr <= end_addr;
            crc <= `FRCC_CRC_INIT;
            exp_hold <= exp_crc;
            rb_clear <= 1'b1;
            o_flag_ready <= 1'b0;
          end
        end
        ST_REQ: begin
          o_mem_rd <= 1'b1;
          o_mem_addr <= cur_addr;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (i_mem_valid) begin
            crc <= crc_new;
            if (cur_addr == last_addr) begin
              state <= ST_IDLE;
              o_flag_ready <= 1'b1;
              o_flag_suspend <= 1'b0;
              rb_load <= fail_set;
            end else begin
              cur_addr <= cur_addr + 32'h00000001;
              state <= ST_REQ;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if ((state != ST_IDLE) && i_suspend_req && !(state == ST_WAIT && i_mem_valid && cur_addr == last_addr)) begin
        o_flag_suspend <= 1'b1;
      end
    end
  end

  // error flags, set wins over clear
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flag_crc_fail <= 1'b0;
      o_flag_range_err <= 1'b0;
    end else begin
      if (fail_set && !i_soft_reset) begin
        o_flag_crc_fail <= 1'b1;
      end else if (i_clear_flags) begin
        o_flag_crc_fail <= 1'b0;
      end
      if (range_set && !i_soft_reset) begin
        o_flag_range_err <= 1'b1;
      end else if (i_clear_flags) begin
        o_flag_range_err <= 1'b0;
      end
    end
  end

  frcc_readback_mem u_readback (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(rb_clear),
    .i_load(rb_load),
    .i_load_data(crc),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data)
  );
endmodule
`default_nettype wire

// *** shared/frcc_defines.vh ***
// constants for the flash range crc check block
// included by every design file of the block
`ifndef FRCC_DEFINES_VH
`define FRCC_DEFINES_VH
`define FRCC_CMD_IFACE 8'h9B
`define FRCC_SUB_CRC 8'h27
`define FRCC_OPT_RANGE 8'hFE
`define FRCC_CMD_READBACK 8'h96
`define FRCC_POLY 64'h42F0E1EBA9EA3693
`define FRCC_CRC_INIT 64'h0000000000000000
`define FRCC_SEQ_LEN 5'h13
`define FRCC_BYTE_CNT_MAX 5'h1F
`define FRCC_RB_BYTES 7'h08
`define FRCC_RB_ADDR_MAX 7'h7F
`endif

// *** verif/frcc_array_model.sv ***
// array model answering byte reads after i_lat cycles
// assumes one outstanding read and i_lat of at least 1
`timescale 1ns/1ns
`default_nettype none
module frcc_array_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_lat,
  input wire logic i_mem_rd,
  input wire logic [31:0] i_mem_addr,
  output var logic [7:0] o_mem_data,
  output var logic o_mem_valid
);
  logic [3:0] cnt;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 4'h0;
      o_mem_valid <= 1'b0;
      o_mem_data <= 8'h00;
    end else begin
      o_mem_valid <= 1'b0;
      // data toggles while not valid
      o_mem_data <= ~o_mem_data;
      if (i_mem_rd) begin
        cnt <= i_lat;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          o_mem_valid <= 1'b1;
          o_mem_data <= i_mem_addr[7:0] ^ 8'h5A;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/frcc_props.sv ***
// assertions on the range crc check block
// sees only frcc_top ports, bound below
`timescale 1ns/1ns
`default_nettype none
module frcc_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_miso_oe,
  input wire logic i_suspend_req,
  input wire logic i_soft_reset,
  input wire logic i_mem_valid,
  input wire logic o_mem_rd,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_flag_ready,
  input wire logic o_flag_suspend,
  input wire logic o_flag_crc_fail,
  input wire logic o_flag_range_err
);
  logic seen;
  logic [31:0] last;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen <= 1'b0;
      last <= 32'h0;
    end else if (o_flag_ready) begin
      seen <= 1'b0;
    end else if (o_mem_rd) begin
      seen <= 1'b1;
      last <= o_mem_addr;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_read_busy:
  assert property (o_mem_rd |-> !o_flag_ready) else $error("array read while idle");
  a_rd_pulse:
  assert property (o_mem_rd |=> !o_mem_rd) else $error("read request too long");
  a_addr_step:
  assert property (o_mem_rd && seen |-> o_mem_addr == last + 32'h1) else $error("address not stepped");
  a_susp_set:
  assert property (i_suspend_req && !o_flag_ready && !i_mem_valid && !i_soft_reset |=> o_flag_suspend)
    else $error("suspend flag not set");
  a_susp_end:
  assert property ($rose(o_flag_ready) |-> !o_flag_suspend) else $error("suspend flag kept");
  a_soft_abort:
  assert property (i_soft_reset |=> o_flag_ready && !o_flag_suspend && !o_mem_rd) else $error("no abort");
  a_fail_end:
  assert property ($rose(o_flag_crc_fail) |-> $rose(o_flag_ready)) else $error("fail flag off end");
  a_range_idle:
  assert property ($rose(o_flag_range_err) |-> o_flag_ready) else $error("range error while busy");
  a_oe_select:
  assert property ($rose(o_spi_miso_oe) |-> !i_spi_cs_n) else $error("miso driven unselected");
endmodule
bind frcc_top frcc_props frcc_props_i (.i_clk, .i_reset_n, .i_spi_cs_n, .o_spi_miso_oe, .i_suspend_req,
  .i_soft_reset, .i_mem_valid, .o_mem_rd, .o_mem_addr, .o_flag_ready, .o_flag_suspend, .o_flag_crc_fail,
  .o_flag_range_err);
`default_nettype wire

// *** verif/frcc_tb.sv ***
// self-checking bench for the range crc check block
// assumes frcc_top, its checker and the array model
`timescale 1ns/1ns
`default_nettype none
`include "frcc_defines.vh"
module testbench;
  logic i_clk = 0, rst_n = 0, sclk = 0, cs_n = 1, mosi = 0, susp = 0, srst = 0, clrf = 0;
  logic [3:0] lat = 4'h1;
  logic [7:0] r, mdat;
  logic [31:0] maddr;
  wire miso, oe, mrd, mval, rdy, sus, fail, rerr;
  integer error_cnt = 0, tests_run = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  frcc_top frcc_top_i (.i_clk(i_clk), .i_reset_n(rst_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_suspend_req(susp), .i_soft_reset(srst), .i_clear_flags(clrf),
    .o_mem_rd(mrd), .o_mem_addr(maddr), .i_mem_data(mdat), .i_mem_valid(mval), .o_flag_ready(rdy),
    .o_flag_suspend(sus), .o_flag_crc_fail(fail), .o_flag_range_err(rerr));
  frcc_array_model frcc_array_model_i (.i_clk(i_clk), .i_reset_n(rst_n), .i_lat(lat), .i_mem_rd(mrd),
    .i_mem_addr(maddr), .o_mem_data(mdat), .o_mem_valid(mval));
  function [63:0] crc_of(input [31:0] s, input [31:0] e);
    reg [31:0] a;
    reg [7:0] d;
    integer b;
    begin
      crc_of = `FRCC_CRC_INIT;
      for (a = s; a <= e; a = a + 1) begin
        d = a[7:0] ^ 8'h5A;
        for (b = 0; b < 8; b = b + 1)
          crc_of = {crc_of[62:0], 1'b0} ^ ((crc_of[63] ^ d[b]) ? `FRCC_POLY : 64'h0);
      end
    end
  endfunction
  task chk(input [8*8-1:0] name, input [63:0] exp, input [63:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task spi_byte(input [7:0] b);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      mosi = b[i];
      #62 sclk = 1;
      r = {r[6:0], oe ? miso : ~miso}; // released pin reads inverted
      #63 sclk = 0;
    end
  endtask
  task frame(input [63:0] crc, input [31:0] s, input [31:0] e, input integer n);
    integer i;
    begin
      #60 cs_n = 0;
      for (i = 0; i < n; i = i + 1)
        spi_byte(i < 3 ? 24'hFE279B >> (8*i) : i < 11 ? crc >> (8*(i-3)) : i < 15 ? s >> (8*(i-11)) : e >> (8*(i-15)));
      #60 cs_n = 1;
      mosi = ~mosi;
    end
  endtask
  task read_rb(input [63:0] exp, input integer n);
    integer i;
    begin
      #60 cs_n = 0;
      spi_byte(`FRCC_CMD_READBACK);
      for (i = 0; i < n; i = i + 1) begin
        spi_byte(8'h00);
        chk("readback", i < 8 ? exp >> (8*i) & 64'hFF : 64'h0, r);
      end
      #60 cs_n = 1;
      mosi = ~mosi;
    end
  endtask
  task wait_done;
    integer i;
    begin
      repeat (6) @(posedge i_clk);
      for (i = 0; i < 3000 && rdy !== 1'b1; i = i + 1)
        @(posedge i_clk);
      #1 chk("ready", 1, rdy);
    end
  endtask
  task pulse(input integer w);
    begin
      @(posedge i_clk) #1 {susp, srst, clrf} = 3'b100 >> w;
      @(posedge i_clk) #1 {susp, srst, clrf} = 3'b000;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    #1 rst_n = 1;
    repeat (4) @(posedge i_clk);
    #1 chk("ready", 1, rdy);
    read_rb(0, 1);
    $display("test reset done");
    frame(~crc_of(7, 7), 7, 7, 19);
    wait_done;
    chk("fail", 1, fail);
    read_rb(crc_of(7, 7), 9);
    $display("test fail done");
    frame(0, 1, 2, 18);
    repeat (10) @(posedge i_clk);
    chk("ready", 1, rdy);
    chk("fail", 1, fail);
    read_rb(crc_of(7, 7), 1);
    pulse(2);
    chk("fail", 0, fail);
    $display("test short done");
    lat = 4'h3;
    frame(crc_of(3, 6), 3, 6, 19);
    repeat (8) @(posedge i_clk);
    chk("busy", 0, rdy);
    pulse(0);
    chk("suspend", 1, sus);
    wait_done;
    chk("suspend", 0, sus);
    chk("fail", 0, fail);
    read_rb(0, 9);
    $display("test pass done");
    frame(0, 9, 8, 19);
    repeat (10) @(posedge i_clk);
    chk("range", 1, rerr);
    chk("ready", 1, rdy);
    pulse(2);
    chk("range", 0, rerr);
    $display("test range done");
    lat = 4'h1;
    frame(~crc_of(7, 7), 7, 7, 19);
    wait_done;
    pulse(1);
    chk("fail", 1, fail);
    read_rb(0, 1);
    $display("test soft clear done");
    lat = 4'h4;
    frame(0, 0, 40, 19);
    repeat (20) @(posedge i_clk);
    chk("busy", 0, rdy);
    @(posedge i_clk) #1 rst_n = 0;
    repeat (2) @(posedge i_clk);
    #1 rst_n = 1;
    repeat (4) @(posedge i_clk);
    #1 chk("ready", 1, rdy);
    chk("fail", 0, fail);
    $display("test hard reset done");
    frame(0, 0, 40, 19);
    repeat (20) @(posedge i_clk);
    chk("busy", 0, rdy);
    pulse(1);
    chk("ready", 1, rdy);
    chk("fail", 0, fail);
    read_rb(0, 2);
    $display("test abort done");
    complete_run;
  end
endmodule
`default_nettype wire
